// ### core/llcss_pkg.sv
/*
 package for the supervisor state machine: states, ratio options, timing.
 assumes a 200 MHz system clock.
*/
`default_nettype none
package llcss_pkg;
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int unsigned CLK_MHZ = 200;
	// times in their own units
	localparam int unsigned FAULT_PAUSE_S = 1;
	localparam int unsigned OCP_SHORT_MS = 2;
	localparam int unsigned OCP_LONG_MS = 50;
	localparam int unsigned WAKE_US = 10;
	localparam int unsigned BOOT_US = 100;
	// cycle counts
	localparam int unsigned FAULT_CYC = FAULT_PAUSE_S * CLK_HZ;
	localparam int unsigned OCP_SHORT_CYC = OCP_SHORT_MS * (CLK_HZ / 1000);
	localparam int unsigned OCP_LONG_CYC = OCP_LONG_MS * (CLK_HZ / 1000);
	localparam int unsigned WAKE_CYC = WAKE_US * CLK_MHZ;
	localparam int unsigned BOOT_CYC = BOOT_US * CLK_MHZ;
	localparam int unsigned CNT_W = 28;
	// ratio options, pin code 1..7
	localparam logic [2:0] OPT_NONE = 3'h0;
	localparam logic [2:0] OPT_SS_OFF = 3'h5;
	localparam logic [2:0] OPT_NO_BURST = 3'h7;
	// ratio in hundredths
	localparam logic [6:0] RATIO_1 = 7'h5f;
	localparam logic [6:0] RATIO_2 = 7'h64;
	localparam logic [6:0] RATIO_3 = 7'h5a;
	localparam logic [6:0] RATIO_4 = 7'h50;
	localparam logic [6:0] RATIO_56 = 7'h3c;
	localparam logic [6:0] RATIO_7 = 7'h28;

	typedef enum logic [2:0] {
		st_startup,
		st_hv_charging,
		st_fet_off,
		st_analog_wake,
		st_program,
		st_charge_boot,
		st_run,
		st_fault
	} llcss_state_type;

	typedef struct packed {
		logic waveform_gen_enable;
		logic regulator_enable;
		logic softstart_enable;
		logic startup_fet_enable;
	} llcss_enables_type;

	typedef struct packed {
		logic [2:0] option;
		logic [6:0] ratio;
		logic       burst_disable;
		logic       ss_init_disable;
	} llcss_ratio_type;
endpackage
`default_nettype wire

// ### core/llcss_qual.sv
/*
 fault qualifier: output rises once input has been high for CYCLES clocks.
 assumes input synchronous to sys_clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module llcss_qual #(
	parameter int unsigned CYCLES = 400000
) (
	// clock and reset
	input  wire logic sys_clk_i,
	input  wire logic rstn_i,
	// raw and qualified fault
	input  wire logic raw_i,
	output var  logic qual_o
);
	logic [27:0] cnt_q;
	logic        done_w;
	localparam logic [27:0] LAST = 28'(CYCLES - 1);

	assign done_w = (cnt_q == LAST);

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q  <= 28'h0;
			qual_o <= 1'b0;
		end else if (!raw_i) begin
			cnt_q  <= 28'h0;
			qual_o <= 1'b0;
		end else begin
			if (!done_w)
				cnt_q <= cnt_q + 28'h1;
			qual_o <= done_w;
		end
	end

	qual_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		qual_o |-> $past(raw_i)) else $error("qualified fault without input");
endmodule
`default_nettype wire

// ### core/llcss_top.sv
/*
 supervisory state machine of a resonant converter controller with
 burst ratio selection. assumes all flags synchronous to sys_clk_i.
*/
`timescale 1ns/100ps
`default_nettype none
module llcss_top #(
	parameter bit          HAS_HV_STARTUP = 1'b1,
	parameter int unsigned FAULT_CYC      = llcss_pkg::FAULT_CYC,
	parameter int unsigned OCP_SHORT_CYC  = llcss_pkg::OCP_SHORT_CYC,
	parameter int unsigned OCP_LONG_CYC   = llcss_pkg::OCP_LONG_CYC,
	parameter int unsigned WAKE_CYC       = llcss_pkg::WAKE_CYC,
	parameter int unsigned BOOT_CYC       = llcss_pkg::BOOT_CYC
) (
	// clock and reset
	input  wire logic                        sys_clk_i,
	input  wire logic                        rstn_i,
	// status flags
	input  wire logic                        trim_done_i,
	input  wire logic                        supply_above_start_flag_i,
	input  wire logic                        supply_below_restart_flag_i,
	input  wire logic                        bulk_start_flag_i,
	input  wire logic                        bulk_stop_flag_i,
	input  wire logic                        regulator_undervoltage_flag_i,
	input  wire logic                        line_zero_cross_flag_i,
	// faults
	input  wire logic                        over_temp_fault_i,
	input  wire logic                        output_overvoltage_flag_i,
	input  wire logic                        peak_current_fault_i,
	input  wire logic                        avg_current_fault_short_i,
	input  wire logic                        avg_current_fault_long_i,
	// ratio select pin measurement
	input  wire logic                        ratio_meas_valid_i,
	input  wire logic [2:0]                  ratio_meas_code_i,
	output var  logic                        ratio_select_source_o,
	// enables and pin controls
	output var  llcss_pkg::llcss_enables_type enables_o,
	output var  logic                        low_side_gate_o,
	output var  logic                        softstart_buffer_o,
	output var  llcss_pkg::llcss_ratio_type   ratio_o,
	output var  llcss_pkg::llcss_state_type   state_o
);
	localparam logic [27:0] FAULT_LAST = 28'(FAULT_CYC - 1);
	localparam logic [27:0] WAKE_LAST  = 28'(WAKE_CYC - 1);
	localparam logic [27:0] BOOT_LAST  = 28'(BOOT_CYC - 1);

	llcss_pkg::llcss_state_type   state_q, state_d;
	llcss_pkg::llcss_enables_type en_d;
	llcss_pkg::llcss_ratio_type   ratio_q, ratio_d;
	logic [27:0] cnt_q;
	logic        ocp_short_w, ocp_long_w;
	logic        run_fault_w, bulk_ok_w, restart_w, timer_done_w;
	logic        ratio_take_w;
	logic [6:0]  ratio_val_w;

	llcss_qual #(.CYCLES(OCP_SHORT_CYC)) u_qual_short (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.raw_i     (avg_current_fault_short_i),
		.qual_o    (ocp_short_w)
	);
	llcss_qual #(.CYCLES(OCP_LONG_CYC)) u_qual_long (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.raw_i     (avg_current_fault_long_i),
		.qual_o    (ocp_long_w)
	);

	assign run_fault_w = over_temp_fault_i | bulk_stop_flag_i |
		output_overvoltage_flag_i | peak_current_fault_i |
		ocp_short_w | ocp_long_w | regulator_undervoltage_flag_i;
	assign bulk_ok_w = bulk_start_flag_i & ~bulk_stop_flag_i &
		~regulator_undervoltage_flag_i;
	assign restart_w = supply_below_restart_flag_i & HAS_HV_STARTUP;
	assign timer_done_w = (state_q == llcss_pkg::st_analog_wake) ?
		(cnt_q == WAKE_LAST) : (state_q == llcss_pkg::st_charge_boot) ?
		(cnt_q == BOOT_LAST) : (cnt_q == FAULT_LAST);

	always_comb begin
		state_d = state_q;
		case (state_q)
			// trim load then charge or skip
			llcss_pkg::st_startup: begin
				if (trim_done_i && HAS_HV_STARTUP)
					state_d = llcss_pkg::st_hv_charging;
				else if (trim_done_i && supply_above_start_flag_i)
					state_d = llcss_pkg::st_fet_off;
			end
			llcss_pkg::st_hv_charging: begin
				if (supply_above_start_flag_i && !supply_below_restart_flag_i)
					state_d = llcss_pkg::st_fet_off;
			end
			llcss_pkg::st_fet_off: begin
				if (restart_w)
					state_d = llcss_pkg::st_hv_charging;
				else if (over_temp_fault_i)
					state_d = llcss_pkg::st_fault;
				else if (bulk_ok_w)
					state_d = llcss_pkg::st_analog_wake;
			end
			llcss_pkg::st_analog_wake: begin
				if (restart_w)
					state_d = llcss_pkg::st_hv_charging;
				else if (over_temp_fault_i)
					state_d = llcss_pkg::st_fault;
				else if (timer_done_w && bulk_ok_w)
					state_d = llcss_pkg::st_program;
			end
			llcss_pkg::st_program: begin
				if (restart_w)
					state_d = llcss_pkg::st_hv_charging;
				else if (over_temp_fault_i)
					state_d = llcss_pkg::st_fault;
				else if (ratio_q.option != llcss_pkg::OPT_NONE)
					state_d = llcss_pkg::st_charge_boot;
			end
			llcss_pkg::st_charge_boot: begin
				if (restart_w)
					state_d = llcss_pkg::st_hv_charging;
				else if (over_temp_fault_i)
					state_d = llcss_pkg::st_fault;
				else if (timer_done_w)
					state_d = llcss_pkg::st_run;
			end
			llcss_pkg::st_run: begin
				if (restart_w)
					state_d = llcss_pkg::st_hv_charging;
				else if (run_fault_w)
					state_d = llcss_pkg::st_fault;
			end
			llcss_pkg::st_fault: begin
				if (timer_done_w)
					state_d = llcss_pkg::st_startup;
			end
			default: state_d = llcss_pkg::st_startup;
		endcase
	end

	always_comb begin
		en_d = '0;
		case (state_d)
			llcss_pkg::st_hv_charging: en_d.startup_fet_enable = 1'b1;
			llcss_pkg::st_fet_off,
			llcss_pkg::st_analog_wake,
			llcss_pkg::st_program,
			llcss_pkg::st_charge_boot: en_d.regulator_enable = 1'b1;
			llcss_pkg::st_run: begin
				en_d.waveform_gen_enable = 1'b1;
				en_d.regulator_enable    = 1'b1;
				en_d.softstart_enable    = 1'b1;
			end
			default: en_d = '0;
		endcase
	end

	assign ratio_val_w = (ratio_meas_code_i == 3'h1) ? llcss_pkg::RATIO_1 :
		(ratio_meas_code_i == 3'h2) ? llcss_pkg::RATIO_2 :
		(ratio_meas_code_i == 3'h3) ? llcss_pkg::RATIO_3 :
		(ratio_meas_code_i == 3'h4) ? llcss_pkg::RATIO_4 :
		(ratio_meas_code_i == 3'h7) ? llcss_pkg::RATIO_7 :
		llcss_pkg::RATIO_56;
	assign ratio_take_w = (state_q == llcss_pkg::st_program) &&
		ratio_meas_valid_i && (ratio_meas_code_i != llcss_pkg::OPT_NONE) &&
		(ratio_q.option == llcss_pkg::OPT_NONE);

	always_comb begin
		ratio_d = ratio_q;
		if (state_q == llcss_pkg::st_fault)
			ratio_d = '0;
		else if (ratio_take_w) begin
			ratio_d.option = ratio_meas_code_i;
			ratio_d.ratio = ratio_val_w;
			ratio_d.burst_disable = (ratio_meas_code_i == llcss_pkg::OPT_NO_BURST);
			ratio_d.ss_init_disable = (ratio_meas_code_i == llcss_pkg::OPT_SS_OFF);
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= llcss_pkg::st_startup;
			state_o <= llcss_pkg::st_startup;
			enables_o <= '0;
			ratio_q <= '0;
			ratio_o <= '0;
			low_side_gate_o <= 1'b0;
			softstart_buffer_o <= 1'b0;
			ratio_select_source_o <= 1'b0;
		end else begin
			state_q <= state_d;
			state_o <= state_d;
			enables_o <= en_d;
			ratio_q <= ratio_d;
			ratio_o <= ratio_d;
			// low gate and ss buffer in boot
			low_side_gate_o <= (state_d == llcss_pkg::st_charge_boot);
			softstart_buffer_o <= (state_d == llcss_pkg::st_charge_boot) &&
				!ratio_d.ss_init_disable;
			ratio_select_source_o <= (state_d == llcss_pkg::st_program) &&
				(ratio_d.option == llcss_pkg::OPT_NONE);
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i)
			cnt_q <= 28'h0;
		else if (state_d != state_q)
			cnt_q <= 28'h0;
		else if (!timer_done_w)
			cnt_q <= cnt_q + 28'h1;
	end

	wire unused_w = line_zero_cross_flag_i;

	fault_enables_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		state_o == llcss_pkg::st_fault |-> enables_o == '0)
		else $error("enables active in fault");
	charge_fet_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		state_o == llcss_pkg::st_hv_charging |->
		enables_o == 4'h1)
		else $error("charging enables wrong");
	run_enables_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		state_o == llcss_pkg::st_run |-> enables_o == 4'he)
		else $error("run enables wrong");
	reg_only_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		state_o inside {llcss_pkg::st_fet_off, llcss_pkg::st_analog_wake,
		llcss_pkg::st_program} |-> enables_o == 4'h4)
		else $error("regulator only enables wrong");
	ratio_fixed_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		$past(ratio_q.option) != llcss_pkg::OPT_NONE &&
		$past(state_q) != llcss_pkg::st_fault |->
		$stable(ratio_q))
		else $error("ratio changed after selection");
	no_burst_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		ratio_q.option == llcss_pkg::OPT_NO_BURST |->
		ratio_q.burst_disable && ratio_q.ratio == 7'h28)
		else $error("option seven not applied");
	ss_skip_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		ratio_q.option == llcss_pkg::OPT_SS_OFF |->
		!softstart_buffer_o && ratio_q.ratio == 7'h3c)
		else $error("option five not applied");
	run_fault_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		state_q == llcss_pkg::st_run && run_fault_w && !restart_w |=>
		state_q == llcss_pkg::st_fault)
		else $error("run fault ignored");
	wake_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		state_q == llcss_pkg::st_fet_off && !bulk_ok_w |=>
		state_q != llcss_pkg::st_analog_wake)
		else $error("wake entered without bulk ok");
	restart_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		state_q == llcss_pkg::st_run && restart_w |=>
		state_q == llcss_pkg::st_hv_charging)
		else $error("restart not taken");
	boot_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		low_side_gate_o == (state_o == llcss_pkg::st_charge_boot))
		else $error("low gate outside boot");
	startup_off_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		state_o == llcss_pkg::st_startup |-> enables_o == '0)
		else $error("enables active in startup");

	run_c: cover property (@(posedge sys_clk_i) state_q == llcss_pkg::st_run);
	fault_c: cover property (@(posedge sys_clk_i)
		state_q == llcss_pkg::st_fault ##1 state_q == llcss_pkg::st_startup);
	opt7_c: cover property (@(posedge sys_clk_i)
		ratio_q.option == llcss_pkg::OPT_NO_BURST);
	restart_c: cover property (@(posedge sys_clk_i)
		state_q == llcss_pkg::st_run ##1 state_q == llcss_pkg::st_hv_charging);
	opt5_c: cover property (@(posedge sys_clk_i)
		ratio_q.option == llcss_pkg::OPT_SS_OFF);
endmodule
`default_nettype wire

// ### verification/llcss_analog_model.sv
/*
 analog side model: supply charge, restart droop, ratio pin measurement.
 assumes bench drives droop and pin code on the falling edge.
*/
`timescale 1ns/100ps
`default_nettype none
module llcss_analog_model (
	// clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       rstn_i,
	// from the supervisor
	input  wire logic       fet_en_i,
	input  wire logic       source_i,
	// scenario controls
	input  wire logic       droop_i,
	input  wire logic [2:0] pin_code_i,
	// comparator flags and measurement
	output var  logic       above_o,
	output var  logic       below_o,
	output var  logic       valid_o,
	output var  logic [2:0] code_o
);
	logic [3:0] chg_q;
	logic [3:0] meas_q;

	// supply charges only while the startup fet conducts
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			chg_q  <= 4'h0;
			meas_q <= 4'h0;
		end else begin
			if (droop_i)
				chg_q <= 4'h0;
			else if (fet_en_i && chg_q != 4'hf)
				chg_q <= chg_q + 4'h1;
			meas_q <= source_i ? meas_q + 4'h1 : 4'h0;
		end
	end

	assign above_o = (chg_q >= 4'h4) && !droop_i;
	assign below_o = droop_i;
	// settled pin voltage only after a few cycles of source current
	assign valid_o = source_i && (meas_q == 4'h3);
	assign code_o  = valid_o ? pin_code_i : ~pin_code_i;
endmodule
`default_nettype wire

// ### verification/llcss_top_bench.sv
/*
 bench for the supervisor: walks every ratio option through startup,
 run and one fault kind each. assumes shortened timing parameters.
*/
`timescale 1ns/100ps
`default_nettype none
module llcss_top_bench;
	localparam int FLT = 20;
	localparam int OS  = 8;
	localparam int OL  = 16;
	localparam int WK  = 4;
	localparam int BT  = 6;
	logic clk, rstn, trim, bstart, droop, above_nohv;
	logic [6:0] flt;
	logic [2:0] pin_code;
	wire logic above, below, valid, source, lsg, ssbuf;
	wire logic [2:0] code;
	llcss_pkg::llcss_enables_type en;
	llcss_pkg::llcss_ratio_type   rat;
	llcss_pkg::llcss_state_type   st, st_nohv;
	int bad_count, n_checks, n;

	llcss_top #(.FAULT_CYC(FLT), .OCP_SHORT_CYC(OS), .OCP_LONG_CYC(OL),
		.WAKE_CYC(WK), .BOOT_CYC(BT)) i_llcss_top (
		.sys_clk_i(clk), .rstn_i(rstn), .trim_done_i(trim),
		.supply_above_start_flag_i(above),
		.supply_below_restart_flag_i(below),
		.bulk_start_flag_i(bstart), .bulk_stop_flag_i(flt[1]),
		.regulator_undervoltage_flag_i(flt[6]),
		.line_zero_cross_flag_i(1'b0), .over_temp_fault_i(flt[0]),
		.output_overvoltage_flag_i(flt[2]), .peak_current_fault_i(flt[3]),
		.avg_current_fault_short_i(flt[4]),
		.avg_current_fault_long_i(flt[5]),
		.ratio_meas_valid_i(valid), .ratio_meas_code_i(code),
		.ratio_select_source_o(source), .enables_o(en),
		.low_side_gate_o(lsg), .softstart_buffer_o(ssbuf),
		.ratio_o(rat), .state_o(st));

	llcss_top #(.HAS_HV_STARTUP(1'b0)) i_llcss_top_nohv (
		.sys_clk_i(clk), .rstn_i(rstn), .trim_done_i(trim),
		.supply_above_start_flag_i(above_nohv),
		.supply_below_restart_flag_i(below),
		.bulk_start_flag_i(1'b0), .bulk_stop_flag_i(flt[1]),
		.regulator_undervoltage_flag_i(flt[6]),
		.line_zero_cross_flag_i(1'b0), .over_temp_fault_i(flt[0]),
		.output_overvoltage_flag_i(flt[2]), .peak_current_fault_i(flt[3]),
		.avg_current_fault_short_i(flt[4]),
		.avg_current_fault_long_i(flt[5]),
		.ratio_meas_valid_i(valid), .ratio_meas_code_i(code),
		.ratio_select_source_o(), .enables_o(), .low_side_gate_o(),
		.softstart_buffer_o(), .ratio_o(), .state_o(st_nohv));

	llcss_analog_model i_llcss_analog_model (
		.sys_clk_i(clk), .rstn_i(rstn), .fet_en_i(en.startup_fet_enable),
		.source_i(source), .droop_i(droop), .pin_code_i(pin_code),
		.above_o(above), .below_o(below), .valid_o(valid), .code_o(code));

	task automatic print_verdict;
		if (bad_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rng(input int v, input int lo, input int hi);
		n_checks++;
		if (v < lo || v > hi) begin
			bad_count++;
			$display("[FAIL] %0t count %0d outside %0d..%0d", $time, v, lo, hi);
		end
	endtask

	task automatic wait_st(input llcss_pkg::llcss_state_type s);
		int k;
		k = 0;
		while (st !== s && k < 300) begin
			@(negedge clk);
			k++;
		end
		chk(st, s);
	endtask

	task automatic dwell(output int c);
		llcss_pkg::llcss_state_type s;
		s = st;
		c = 0;
		while (st === s && c < 2000) begin
			@(negedge clk);
			c++;
		end
	endtask

	function automatic llcss_pkg::llcss_ratio_type exp_rat(input int o);
		llcss_pkg::llcss_ratio_type r;
		r.option = o[2:0];
		case (o)
			1: r.ratio = llcss_pkg::RATIO_1;
			2: r.ratio = llcss_pkg::RATIO_2;
			3: r.ratio = llcss_pkg::RATIO_3;
			4: r.ratio = llcss_pkg::RATIO_4;
			7: r.ratio = llcss_pkg::RATIO_7;
			default: r.ratio = llcss_pkg::RATIO_56;
		endcase
		r.burst_disable   = (o == 7);
		r.ss_init_disable = (o == 5);
		return r;
	endfunction

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		print_verdict();
	end

	initial begin
		rstn = 1'b0; trim = 1'b0; bstart = 1'b0; droop = 1'b0;
		above_nohv = 1'b0; flt = 7'h00; pin_code = 3'h1;
		bad_count = 0; n_checks = 0;
		repeat (6) @(negedge clk);
		rstn = 1'b1;
		repeat (3) @(negedge clk);
		chk(st, llcss_pkg::st_startup);
		chk(en, 4'h0);
		trim = 1'b1;
		repeat (2) @(negedge clk);
		chk(st_nohv, llcss_pkg::st_startup);
		above_nohv = 1'b1;
		repeat (2) @(negedge clk);
		chk(st_nohv, llcss_pkg::st_fet_off);
		for (int i = 1; i <= 7; i++) begin
			pin_code = i[2:0];
			wait_st(llcss_pkg::st_hv_charging);
			chk(en, 4'h1);
			wait_st(llcss_pkg::st_fet_off);
			chk(en, 4'h4);
			if (i == 1) begin
				repeat (3) @(negedge clk);
				chk(st, llcss_pkg::st_fet_off);
				droop = 1'b1;
				wait_st(llcss_pkg::st_hv_charging);
				chk(en, 4'h1);
				droop = 1'b0;
				wait_st(llcss_pkg::st_fet_off);
				bstart = 1'b1;
			end
			wait_st(llcss_pkg::st_analog_wake);
			chk(en, 4'h4);
			dwell(n);
			rng(n, WK, WK + 1);
			chk(st, llcss_pkg::st_program);
			chk(en, 4'h4);
			@(negedge clk);
			chk(source, 1'b1);
			wait_st(llcss_pkg::st_charge_boot);
			chk(lsg, 1'b1);
			chk(ssbuf, i != 5);
			chk(en, 4'h4);
			dwell(n);
			rng(n, BT, BT + 1);
			chk(st, llcss_pkg::st_run);
			chk(en, 4'he);
			chk(rat, exp_rat(i));
			chk(source, 1'b0);
			pin_code = ~pin_code;
			repeat (5) @(negedge clk);
			chk(rat, exp_rat(i));
			// supply droop in run: back to charging, ratio kept
			droop = 1'b1;
			wait_st(llcss_pkg::st_hv_charging);
			chk(en, 4'h1);
			chk(rat, exp_rat(i));
			droop = 1'b0;
			wait_st(llcss_pkg::st_program);
			chk(source, 1'b0);
			wait_st(llcss_pkg::st_run);
			chk(rat, exp_rat(i));
			flt[i-1] = 1'b1;
			dwell(n);
			rng(n, i == 5 ? OS : (i == 6 ? OL : 0),
				(i == 5 ? OS : (i == 6 ? OL : 0)) + 3);
			chk(st, llcss_pkg::st_fault);
			flt = 7'h00;
			chk(en, 4'h0);
			dwell(n);
			rng(n, FLT, FLT + 1);
			chk(st, llcss_pkg::st_startup);
			chk(rat.option, llcss_pkg::OPT_NONE);
		end
		print_verdict();
	end
endmodule
`default_nettype wire
